// ### core/plc_regs.vh
// Register map, field layouts and reset values of the parallel line controller.
// Assumes a 32-bit Avalon-MM slave with byte addresses (offsets decoded as they stand).
`ifndef PLC_REGS_VH
`define PLC_REGS_VH

// Byte offsets
`define PLC_PU_EN_OFS     8'h00
`define PLC_PU_DIS_OFS    8'h04
`define PLC_PU_ST_OFS     8'h08
`define PLC_PD_EN_OFS     8'h0C
`define PLC_PD_DIS_OFS    8'h10
`define PLC_PD_ST_OFS     8'h14
`define PLC_OWN_EN_OFS    8'h18
`define PLC_OWN_DIS_OFS   8'h1C
`define PLC_OWN_ST_OFS    8'h20
`define PLC_FSEL_LO_OFS   8'h24
`define PLC_FSEL_HI_OFS   8'h28
`define PLC_DRV_EN_OFS    8'h2C
`define PLC_DRV_DIS_OFS   8'h30
`define PLC_DRV_ST_OFS    8'h34
`define PLC_OUT_SET_OFS   8'h38
`define PLC_OUT_CLR_OFS   8'h3C
`define PLC_OUT_ST_OFS    8'h40
`define PLC_MSK_EN_OFS    8'h44
`define PLC_MSK_DIS_OFS   8'h48
`define PLC_MSK_ST_OFS    8'h4C
`define PLC_OD_EN_OFS     8'h50
`define PLC_OD_DIS_OFS    8'h54
`define PLC_OD_ST_OFS     8'h58
`define PLC_PIN_ST_OFS    8'h5C

// Reset values
`define PLC_PU_RST        32'h0000_0000
`define PLC_PD_RST        32'h0FFF_FFFF
`define PLC_FSEL_RST      32'h0000_0000
`define PLC_DRV_RST       32'h0000_0000
`define PLC_OUT_RST       32'h0000_0000
`define PLC_MSK_RST       32'h0000_0000
`define PLC_OD_RST        32'h0000_0000
`define PLC_OWN_RST       32'hFFFF_FFFF

// Function select codes {high, low}
`define PLC_FN_A          2'b00
`define PLC_FN_B          2'b01
`define PLC_FN_C          2'b10
`define PLC_FN_D          2'b11

`endif

// ### core/plc_line_ctrl.v
// Parallel line controller: 32 general purpose lines with peripheral muxing.
// Assumes an Avalon-MM master on mclk, pins resolved by the bench from oe_n.
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "plc_regs.vh"

module plc_line_ctrl #(
  parameter NLINES = 32, // one bit per line in every register
  parameter [31:0] OWN_RESET = `PLC_OWN_RST,
  parameter [31:0] PERIPH_PRESENT = 32'hFFFF_FFFF
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Peripheral clock enable from power management
  input wire periph_clk_en,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Pins
  input wire [NLINES-1:0] pin_in,
  output reg [NLINES-1:0] pin_out,
  output reg [NLINES-1:0] pin_oe_n,
  output wire [NLINES-1:0] pin_pullup_en,
  output wire [NLINES-1:0] pin_pulldown_en,
  // Peripheral functions A..D, packed {D,C,B,A} per line group
  input wire [4*NLINES-1:0] periph_out,
  input wire [4*NLINES-1:0] periph_oe,
  output wire [NLINES-1:0] periph_in
);

  // Configuration state, one bit per line
  reg [NLINES-1:0] pu_q;
  reg [NLINES-1:0] pd_q;
  reg [NLINES-1:0] own_q;
  reg [NLINES-1:0] fsel_lo_q;
  reg [NLINES-1:0] fsel_hi_q;
  reg [NLINES-1:0] drv_q;
  reg [NLINES-1:0] out_q;
  reg [NLINES-1:0] msk_q;
  reg [NLINES-1:0] od_q;
  // Pin level capture
  reg [NLINES-1:0] sync1_q;
  reg [NLINES-1:0] sync2_q;
  reg [NLINES-1:0] pin_lvl_q;
  // Bus side
  reg rd_done_q;
  reg [31:0] rd_word;
  wire [NLINES-1:0] wd;
  wire [NLINES-1:0] present;
  wire wr;
  // One strobe per writable offset, decoded once for all register blocks
  wire wr_pu_en;
  wire wr_pu_dis;
  wire wr_pd_en;
  wire wr_pd_dis;
  wire wr_own_en;
  wire wr_own_dis;
  wire wr_fsel_lo;
  wire wr_fsel_hi;
  wire wr_drv_en;
  wire wr_drv_dis;
  wire wr_out_set;
  wire wr_out_clr;
  wire wr_out_dir;
  wire wr_msk_en;
  wire wr_msk_dis;
  wire wr_od_en;
  wire wr_od_dis;
  // Per-line output value and drive ahead of the open-drain stage
  wire [NLINES-1:0] line_val;
  wire [NLINES-1:0] line_drv;

  // Byte lanes merged into one word; partial writes act only on enabled lanes
  assign wd = avs_writedata[NLINES-1:0] &
    {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr = avs_write;
  assign present = PERIPH_PRESENT[NLINES-1:0];

  // Pull, ownership and function select strobes; an unmapped offset raises none and is ignored
  assign wr_pu_en = wr & (avs_address == `PLC_PU_EN_OFS);
  assign wr_pu_dis = wr & (avs_address == `PLC_PU_DIS_OFS);
  assign wr_pd_en = wr & (avs_address == `PLC_PD_EN_OFS);
  assign wr_pd_dis = wr & (avs_address == `PLC_PD_DIS_OFS);
  assign wr_own_en = wr & (avs_address == `PLC_OWN_EN_OFS);
  assign wr_own_dis = wr & (avs_address == `PLC_OWN_DIS_OFS);
  assign wr_fsel_lo = wr & (avs_address == `PLC_FSEL_LO_OFS);
  assign wr_fsel_hi = wr & (avs_address == `PLC_FSEL_HI_OFS);

  // Output path strobes
  assign wr_drv_en = wr & (avs_address == `PLC_DRV_EN_OFS);
  assign wr_drv_dis = wr & (avs_address == `PLC_DRV_DIS_OFS);
  assign wr_out_set = wr & (avs_address == `PLC_OUT_SET_OFS);
  assign wr_out_clr = wr & (avs_address == `PLC_OUT_CLR_OFS);
  assign wr_out_dir = wr & (avs_address == `PLC_OUT_ST_OFS);
  assign wr_msk_en = wr & (avs_address == `PLC_MSK_EN_OFS);
  assign wr_msk_dis = wr & (avs_address == `PLC_MSK_DIS_OFS);
  assign wr_od_en = wr & (avs_address == `PLC_OD_EN_OFS);
  assign wr_od_dis = wr & (avs_address == `PLC_OD_DIS_OFS);

  // Writes complete at once; reads stall one cycle to register data.
  // A read sees waitrequest high in its first cycle and low in the next,
  // with the data already in the output register by then. Trades one
  // cycle of read latency for a flop-driven data bus.
  assign avs_waitrequest = avs_read & ~rd_done_q;

  // Read handshake
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= avs_read & ~rd_done_q;
    end
  end

  // All configuration runs on mclk regardless of periph_clk_en
  // Pull-up status; enable refused where the pull-down is on (bit 0)
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pu_q <= `PLC_PU_RST;
    end else if (wr_pu_en) begin
      pu_q <= pu_q & ~(wd & pd_q);
    end else if (wr_pu_dis) begin
      pu_q <= pu_q | wd;
    end
  end

  // Pull-down status; enable refused where the pull-up is on
  // Top four lines come out of reset with both resistors on, as specified
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pd_q <= `PLC_PD_RST;
    end else if (wr_pd_en) begin
      pd_q <= pd_q & ~(wd & pu_q);
    end else if (wr_pd_dis) begin
      pd_q <= pd_q | wd;
    end
  end

  // Ownership; a release is refused on lines with no peripheral behind them
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      own_q <= OWN_RESET[NLINES-1:0] | ~PERIPH_PRESENT[NLINES-1:0];
    end else if (wr_own_en) begin
      own_q <= own_q | wd;
    end else if (wr_own_dis) begin
      own_q <= own_q & ~(wd & present);
    end
  end

  // Function select low bit; written whatever the line's owner
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fsel_lo_q <= `PLC_FSEL_RST;
    end else if (wr_fsel_lo) begin
      fsel_lo_q <= wd | (fsel_lo_q & ~byte_mask(avs_byteenable));
    end
  end

  // Function select high bit; disabled byte lanes keep their value
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fsel_hi_q <= `PLC_FSEL_RST;
    end else if (wr_fsel_hi) begin
      fsel_hi_q <= wd | (fsel_hi_q & ~byte_mask(avs_byteenable));
    end
  end

  // Drive status; kept even while a peripheral owns the line
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      drv_q <= `PLC_DRV_RST;
    end else if (wr_drv_en) begin
      drv_q <= drv_q | wd;
    end else if (wr_drv_dis) begin
      drv_q <= drv_q & ~wd;
    end
  end

  // Output data; set, clear or masked direct write, in any ownership
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_q <= `PLC_OUT_RST;
    end else if (wr_out_set) begin
      out_q <= out_q | wd;
    end else if (wr_out_clr) begin
      out_q <= out_q & ~wd;
    end else if (wr_out_dir) begin
      // Disabled byte lanes count as masked, so they keep their level
      out_q <= (out_q & ~(msk_q & byte_mask(avs_byteenable))) | (wd & msk_q);
    end
  end

  // Direct-write mask; zero after reset so direct writes change nothing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      msk_q <= `PLC_MSK_RST;
    end else if (wr_msk_en) begin
      msk_q <= msk_q | wd;
    end else if (wr_msk_dis) begin
      msk_q <= msk_q & ~wd;
    end
  end

  // Open-drain selection, independent of ownership
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      od_q <= `PLC_OD_RST;
    end else if (wr_od_en) begin
      od_q <= od_q | wd;
    end else if (wr_od_dis) begin
      od_q <= od_q & ~wd;
    end
  end

  function [31:0] byte_mask;
    input [3:0] be;
    begin
      byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Pin synchroniser; only the second stage reads the first
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_q <= {NLINES{1'b0}};
      sync2_q <= {NLINES{1'b0}};
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Level status freezes when the peripheral clock is off
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_lvl_q <= {NLINES{1'b0}};
    end else if (periph_clk_en) begin
      pin_lvl_q <= sync2_q;
    end
  end

  // Peripherals always see the raw pin level, no mux on the input side
  assign periph_in = pin_in;
  // Status 1 means off, so invert for the pad controls
  assign pin_pullup_en = ~pu_q;
  assign pin_pulldown_en = ~pd_q;

  // Per-line output mux; only output value and drive pass the select
  genvar i;
  generate
    for (i = 0; i < NLINES; i = i + 1) begin : g_line
      wire [1:0] sel = {fsel_hi_q[i], fsel_lo_q[i]};
      wire ctl = own_q[i] | ~present[i];
      // Controller-owned lines take data and drive from the registers
      assign line_val[i] = ctl ? out_q[i] : periph_out[4*i + sel];
      assign line_drv[i] = ctl ? drv_q[i] : periph_oe[4*i + sel];
    end
  endgenerate

  // Pad stage; open-drain lines drive only low and release for high
  // One process for all lines keeps a single driver per output vector
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= {NLINES{1'b0}};
      pin_oe_n <= {NLINES{1'b1}};
    end else begin
      pin_out <= line_val & ~od_q;
      pin_oe_n <= ~(line_drv & ~(od_q & line_val));
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      `PLC_PU_ST_OFS: rd_word = pu_q;
      `PLC_PD_ST_OFS: rd_word = pd_q;
      `PLC_OWN_ST_OFS: rd_word = own_q | ~present;
      `PLC_FSEL_LO_OFS: rd_word = fsel_lo_q;
      `PLC_FSEL_HI_OFS: rd_word = fsel_hi_q;
      `PLC_DRV_ST_OFS: rd_word = drv_q;
      `PLC_OUT_ST_OFS: rd_word = out_q;
      `PLC_MSK_ST_OFS: rd_word = msk_q;
      `PLC_OD_ST_OFS: rd_word = od_q;
      `PLC_PIN_ST_OFS: rd_word = pin_lvl_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data registered on the stall cycle, held until the next read
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~rd_done_q) begin
      avs_readdata <= rd_word;
    end
  end

endmodule // plc_line_ctrl

// ### dv/plc_line_ctrl_props.sv
// Checker: pull guards, bus timing, pin relations.
// Assumes a bind into plc_line_ctrl.
`timescale 1ns/1ps
module plc_line_ctrl_props (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  // Pins
  input wire [31:0] pin_in,
  input wire [31:0] pin_oe_n,
  input wire [31:0] pin_pullup_en,
  input wire [31:0] pin_pulldown_en,
  input wire [31:0] periph_in
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Whole-word writes only; lane masking is left to the bench
  wire fw = avs_write && avs_byteenable == 4'hF;
  // Enables blocked by the opposite resistor as it stood before the write
  pu_on_a: assert property (fw && avs_address == 8'h00 |=> pin_pullup_en ==
    ($past(pin_pullup_en) | $past(avs_writedata) & ~$past(pin_pulldown_en))) else $error("pull-up enable");
  pd_on_a: assert property (fw && avs_address == 8'h0C |=> pin_pulldown_en ==
    ($past(pin_pulldown_en) | $past(avs_writedata) & ~$past(pin_pullup_en))) else $error("pull-down enable");
  pu_off_a: assert property (fw && avs_address == 8'h04 |=>
    pin_pullup_en == ($past(pin_pullup_en) & ~$past(avs_writedata))) else $error("pull-up disable");
  pd_off_a: assert property (fw && avs_address == 8'h10 |=>
    pin_pulldown_en == ($past(pin_pulldown_en) & ~$past(avs_writedata))) else $error("pull-down disable");
  wr_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer");
  periph_in_a: assert property (periph_in == pin_in) else $error("peripheral input");
  rst_pins_a: assert property ($fell(rst) |-> pin_pullup_en == 32'hFFFF_FFFF &&
    pin_pulldown_en == 32'hF000_0000 && &pin_oe_n) else $error("reset pins");
endmodule // plc_line_ctrl_props

bind plc_line_ctrl plc_line_ctrl_props i_plc_line_ctrl_props (.mclk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_waitrequest, .pin_in, .pin_oe_n, .pin_pullup_en, .pin_pulldown_en, .periph_in);

// ### dv/plc_far_side.sv
// Far side: pin resolver and four peripheral functions.
// Assumes one {D,C,B,A} pattern shared by all lines.
`timescale 1ns/1ps
module plc_far_side (
  // Clock
  input wire mclk,
  // Controller pins
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe_n,
  input wire [31:0] pin_pullup_en,
  input wire [31:0] pin_pulldown_en,
  output wire [31:0] pin_in,
  // Peripheral pattern from the bench
  input wire [3:0] fn_val,
  input wire [3:0] fn_drv,
  output wire [127:0] periph_out,
  output wire [127:0] periph_oe
);
  // Floating wire toggles so a stale level never passes
  reg flip_q = 1'b0;
  always @(posedge mclk) flip_q <= ~flip_q;
  // Driver first, then pull-up, then pull-down
  assign pin_in = ~pin_oe_n & pin_out | pin_oe_n & (pin_pullup_en | ~pin_pulldown_en & {32{flip_q}});
  // Same nibble on every line
  assign periph_out = {32{fn_val}};
  assign periph_oe = {32{fn_drv}};
endmodule // plc_far_side

// ### dv/plc_line_ctrl_bench.sv
// Bench: register rows, mux, open drain, pin status, reset.
// Assumes plc_far_side on the pins.
`timescale 1ns/1ps
module plc_line_ctrl_bench;
  // Stimulus
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg periph_clk_en = 1'b0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [7:0] avs_address = 8'h0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hF;
  reg [3:0] fn_val = 4'h0;
  reg [3:0] fn_drv = 4'h0;
  // Observed
  wire avs_waitrequest;
  wire [31:0] avs_readdata, pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_pulldown_en, periph_in;
  wire [127:0] periph_out, periph_oe;
  reg [31:0] q;
  reg [79:0] rows [0:14];
  integer err_total = 0;
  integer compares = 0;
  integer i;
  always #4 mclk = ~mclk;
  // Line 31 has no peripheral
  plc_line_ctrl #(.PERIPH_PRESENT(32'h7FFF_FFFF)) i_plc_line_ctrl (.mclk, .rst, .periph_clk_en, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in,
    .pin_out, .pin_oe_n, .pin_pullup_en, .pin_pulldown_en, .periph_out, .periph_oe, .periph_in);
  plc_far_side i_plc_far_side (.mclk, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_pulldown_en, .pin_in, .fn_val,
    .fn_drv, .periph_out, .periph_oe);
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Request held until waitrequest is seen low
  task acc(input rd, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      avs_read <= rd;
      avs_write <= !rd;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge mclk); while (avs_waitrequest === 1'b1);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    begin
      acc(1'b1, a, 32'h0);
      chk(q, e);
    end
  endtask
  task settle;
    repeat (5) @(negedge mclk);
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge mclk);
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    rows[0] = {8'h04, 32'hFFFF_FFFF, 8'h08, 32'hFFFF_FFFF};
    rows[1] = {8'h0C, 32'hFF, 8'h14, 32'h0FFF_FF00};
    rows[2] = {8'h00, 32'hFFFF, 8'h08, 32'hFFFF_00FF};
    rows[3] = {8'h0C, 32'hFF00, 8'h14, 32'h0FFF_FF00};
    rows[4] = {8'h1C, 32'hFFFF_FFFF, 8'h20, 32'h8000_0000};
    rows[5] = {8'h18, 32'hF, 8'h20, 32'h8000_000F};
    rows[6] = {8'h24, 32'h5555_5555, 8'h24, 32'h5555_5555};
    rows[7] = {8'h28, 32'h3333_3333, 8'h28, 32'h3333_3333};
    rows[8] = {8'h2C, 32'hF0, 8'h34, 32'hF0};
    rows[9] = {8'h38, 32'hA5, 8'h40, 32'hA5};
    rows[10] = {8'h40, 32'hFFFF_FFFF, 8'h40, 32'hA5};
    rows[11] = {8'h44, 32'hF, 8'h4C, 32'hF};
    rows[12] = {8'h40, 32'hA, 8'h40, 32'hAA};
    rows[13] = {8'h50, 32'h1, 8'h58, 32'h1};
    rows[14] = {8'h60, 32'hFFFF_FFFF, 8'h60, 32'h0};
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Rows run with the peripheral clock gated
    for (i = 0; i < 15; i = i + 1) begin
      acc(1'b0, rows[i][79:72], rows[i][71:40]);
      rchk(rows[i][39:32], rows[i][31:0]);
    end
    $display("register rows done");
    // Lines 4..7 select D, C, B, A
    fn_val <= 4'hA;
    fn_drv <= 4'hF;
    settle;
    chk({pin_oe_n[31], pin_oe_n[7:4], pin_out[7:4]}, 9'h105);
    @(posedge mclk);
    fn_val <= 4'h5;
    fn_drv <= 4'h6;
    settle;
    chk({pin_oe_n[7:4], pin_out[6:5]}, 6'h25);
    // Line 0 open drain, lines 3..0 controller-owned
    acc(1'b0, 8'h2C, 32'hF);
    settle;
    chk({pin_oe_n[3:0], pin_out[3:0]}, 8'h0A);
    acc(1'b0, 8'h38, 32'h1);
    acc(1'b0, 8'h10, 32'h1);
    acc(1'b0, 8'h00, 32'h1);
    settle;
    chk({pin_oe_n[0], periph_in[0]}, 2'h3);
    $display("pin drive done");
    // Pin status follows only with the clock running
    @(posedge mclk);
    fn_drv <= 4'hF;
    periph_clk_en <= 1'b1;
    settle;
    rchk(8'h5C, 32'h2AAA_AAAB);
    periph_clk_en <= 1'b0;
    fn_val <= 4'hA;
    settle;
    rchk(8'h5C, 32'h2AAA_AAAB);
    $display("pin status done");
    // Second reset in mid-run
    rst <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rchk(8'h08, 32'h0);
    rchk(8'h14, 32'h0FFF_FFFF);
    rchk(8'h20, 32'hFFFF_FFFF);
    rchk(8'h28, 32'h0);
    rchk(8'h4C, 32'h0);
    rchk(8'h58, 32'h0);
    // Only byte lane 1 of a select write lands
    avs_byteenable <= 4'h2;
    acc(1'b0, 8'h24, 32'hFFFF_FFFF);
    avs_byteenable <= 4'hF;
    rchk(8'h24, 32'h0000_FF00);
    $display("reset done");
    complete_run;
  end
endmodule // plc_line_ctrl_bench
